/* common/nc_pkg.sv */
package nc_pkg;
    // Register offsets on the core register port.
    localparam logic [2:0] OFS_PTR_HI = 3'h2;
    localparam logic [2:0] OFS_PTR_LO = 3'h3;
    localparam logic [2:0] OFS_DATA   = 3'h4;
    localparam logic [2:0] OFS_CONFIG = 3'h6;
    localparam logic [2:0] OFS_SUBREG = 3'h7;
    // Subaddress codes for the shared register at OFS_SUBREG.
    localparam logic [1:0] SUB_TENT_ID  = 2'h0;
    localparam logic [1:0] SUB_NODE_ID  = 2'h1;
    localparam logic [1:0] SUB_SETUP    = 2'h2;
    localparam logic [1:0] SUB_NEXT_ID  = 2'h3;
    // Pointer high fields.
    localparam int PH_READ_DIR = 7;
    localparam int PH_AUTOSTEP = 6;
    // Configuration fields.
    localparam int CFG_BACKPLANE = 2;
    // Setup fields.
    localparam int SU_PULSE_STYLE  = 7;
    localparam int SU_FOUR_REFUSE  = 6;
    localparam int SU_TIMEOUT_DIV3 = 5;
    localparam int SU_PROMISC      = 4;
    localparam int SU_PRESC_LSB    = 1;
    localparam int SU_SLOW_ARB     = 0;
    localparam logic [7:0] SETUP_RESET  = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] NODE_RESET   = 8'h00;
    // Refusal thresholds.
    localparam logic [7:0] REFUSE_FEW  = 8'h04;
    localparam logic [7:0] REFUSE_MANY = 8'h80;
    // Rate prescaler: base divisor 8, first reserved code 110.
    localparam logic [8:0] PRESC_BASE     = 9'h008;
    localparam logic [2:0] PRESC_RESERVED = 3'h6;
    // Host pacing between data register accesses, in cycles.
    localparam logic [1:0] HOST_GAP = 2'h3;
    localparam int RAM_AW = 10;
endpackage : nc_pkg

/* common/nc_core_if.sv */
`timescale 1ns/10ps
interface nc_core_if;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport dev (
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        output rdata
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input  rdata
    );
endinterface : nc_core_if

/* rtl/nc_dev.sv */
`timescale 1ns/10ps
module nc_dev
    import nc_pkg::*;
#(
    parameter int RAM_DEPTH = 1024
) (
    // Clock and reset.
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // Register port toward the microcontroller core.
    nc_core_if.dev          bus,
    // Line pulse request and pin.
    input  wire logic       pulse_req_in,
    output logic            first_line_pulse_out,
    output logic            first_line_pulse_oe_n_out,
    // Free buffer enquiry refusals.
    input  wire logic       refusal_in,
    input  wire logic       refusal_clr_in,
    output logic            excess_refusal_flag_out,
    // Received packet header.
    input  wire logic       rx_valid_in,
    input  wire logic [7:0] rx_dest_id_in,
    output logic            rx_accept_out,
    output logic            rx_ack_out,
    // Timing controls for the protocol engine.
    output logic            timeout_divide_three_out,
    output logic            rate_tick_out,
    output logic            arb_tick_out
);
    logic [7:0]        mem [RAM_DEPTH];
    logic [RAM_AW-1:0] ptr_r;
    logic              read_direction_r;
    logic              pointer_autostep_r;
    logic [7:0]        config_r;
    logic [7:0]        setup_r;
    logic [7:0]        node_id_r;
    logic [7:0]        wbuf_r;
    logic [7:0]        rbuf_r;
    logic              commit_pend_r;
    logic              fetch_pend_r;
    logic              arb_phase_r;
    logic [7:0]        refuse_cnt_r;
    logic [8:0]        rate_cnt_r;
    logic [7:0]        rdata_r;
    logic              arb_tick;
    logic              wr_ptr_hi;
    logic              wr_ptr_lo;
    logic              wr_data;
    logic              rd_data;
    logic              wr_sub;
    logic              do_commit;
    logic              do_fetch;
    logic [2:0]        presc;
    logic [8:0]        rate_lim;
    logic [7:0]        refuse_lim;

    function automatic logic is_wr(input logic [2:0] a, input logic [2:0] o);
        return bus.wr && (a == o);
    endfunction : is_wr

    assign wr_ptr_hi = is_wr(bus.addr, OFS_PTR_HI);
    assign wr_ptr_lo = is_wr(bus.addr, OFS_PTR_LO);
    assign wr_data   = is_wr(bus.addr, OFS_DATA);
    assign wr_sub    = is_wr(bus.addr, OFS_SUBREG);
    assign rd_data   = bus.rd && (bus.addr == OFS_DATA);
    assign bus.rdata = rdata_r;

    // Buffer arbitration runs every cycle, or every second one when slowed.
    assign arb_tick  = !setup_r[SU_SLOW_ARB] || arb_phase_r;
    // A pending write commit is served before a pending prefetch.
    assign do_commit = arb_tick && commit_pend_r;
    assign do_fetch  = arb_tick && fetch_pend_r && !commit_pend_r;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            arb_phase_r  <= 1'b0;
            arb_tick_out <= 1'b0;
        end else begin
            arb_phase_r  <= !arb_phase_r;
            arb_tick_out <= arb_tick;
        end
    end

    // Pointer high: direction, autostep and upper address bits.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            read_direction_r   <= 1'b0;
            pointer_autostep_r <= 1'b0;
        end else if (wr_ptr_hi) begin
            read_direction_r   <= bus.wdata[PH_READ_DIR];
            pointer_autostep_r <= bus.wdata[PH_AUTOSTEP];
        end
    end

    // The full address only takes effect on the low write, so a high write
    // on its own leaves the live pointer alone until the low byte arrives.
    logic [1:0] ptr_hi_stage_r;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ptr_hi_stage_r <= 2'h0;
        end else if (wr_ptr_hi) begin
            ptr_hi_stage_r <= bus.wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ptr_r <= '0;
        end else if (wr_ptr_lo) begin
            ptr_r <= {ptr_hi_stage_r, bus.wdata};
        end else if ((do_commit || rd_data) && pointer_autostep_r) begin
            // Natural overflow of the ten-bit pointer wraps to zero.
            ptr_r <= ptr_r + 1'b1;
        end
    end

    // Write buffer: the access completes at once, the RAM sees it later.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wbuf_r        <= 8'h00;
            commit_pend_r <= 1'b0;
        end else if (wr_data) begin
            wbuf_r        <= bus.wdata;
            commit_pend_r <= 1'b1;
        end else if (do_commit) begin
            commit_pend_r <= 1'b0;
        end
    end

    // Prefetch after a pointer load in read direction or a stepped read.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            fetch_pend_r <= 1'b0;
        end else if (wr_ptr_lo) begin
            fetch_pend_r <= read_direction_r;
        end else if (rd_data && pointer_autostep_r) begin
            fetch_pend_r <= 1'b1;
        end else if (do_fetch) begin
            fetch_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (do_commit) begin
            mem[ptr_r] <= wbuf_r;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rbuf_r <= 8'h00;
        end else if (do_fetch) begin
            rbuf_r <= mem[ptr_r];
        end
    end

    // Configuration, node identifier and setup registers.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            config_r <= CONFIG_RESET;
        end else if (is_wr(bus.addr, OFS_CONFIG)) begin
            config_r <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            setup_r   <= SETUP_RESET;
            node_id_r <= NODE_RESET;
        end else if (wr_sub) begin
            if (config_r[1:0] == SUB_SETUP) begin
                setup_r <= bus.wdata;
            end
            if (config_r[1:0] == SUB_NODE_ID) begin
                node_id_r <= bus.wdata;
            end
        end
    end

    // Read answers appear the cycle after the read strobe.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_PTR_HI: rdata_r <= {read_direction_r, pointer_autostep_r,
                                        4'h0, ptr_r[9:8]};
                OFS_PTR_LO: rdata_r <= ptr_r[7:0];
                OFS_DATA:   rdata_r <= rbuf_r;
                OFS_CONFIG: rdata_r <= config_r;
                OFS_SUBREG: begin
                    case (config_r[1:0])
                        SUB_SETUP:   rdata_r <= setup_r;
                        SUB_NODE_ID: rdata_r <= node_id_r;
                        default:     rdata_r <= 8'h00;
                    endcase
                end
                default:    rdata_r <= 8'h00;
            endcase
        end
    end

    // Line pulse pin; the line is active low. Outside backplane mode the
    // driver is always push-pull.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            first_line_pulse_out      <= 1'b0;
            first_line_pulse_oe_n_out <= 1'b1;
        end else if (!config_r[CFG_BACKPLANE]
                     || setup_r[SU_PULSE_STYLE]) begin
            first_line_pulse_out      <= !pulse_req_in;
            first_line_pulse_oe_n_out <= 1'b0;
        end else begin
            first_line_pulse_out      <= 1'b0;
            first_line_pulse_oe_n_out <= !pulse_req_in;
        end
    end

    // Refusal counter; the flag set wins over a simultaneous clear.
    assign refuse_lim = setup_r[SU_FOUR_REFUSE] ? REFUSE_FEW : REFUSE_MANY;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            refuse_cnt_r            <= 8'h00;
            excess_refusal_flag_out <= 1'b0;
        end else begin
            if (refusal_in && refuse_cnt_r + 1'b1 >= refuse_lim) begin
                excess_refusal_flag_out <= 1'b1;
                refuse_cnt_r            <= 8'h00;
            end else begin
                if (refusal_clr_in) begin
                    excess_refusal_flag_out <= 1'b0;
                end
                if (refusal_clr_in) begin
                    refuse_cnt_r <= 8'h00;
                end else if (refusal_in) begin
                    refuse_cnt_r <= refuse_cnt_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            timeout_divide_three_out <= 1'b0;
        end else begin
            timeout_divide_three_out <= setup_r[SU_TIMEOUT_DIV3];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_accept_out <= 1'b0;
            rx_ack_out    <= 1'b0;
        end else begin
            rx_accept_out <= rx_valid_in && (setup_r[SU_PROMISC]
                             || rx_dest_id_in == node_id_r);
            rx_ack_out    <= rx_valid_in
                             && rx_dest_id_in == node_id_r;
        end
    end

    // Rate prescaler; reserved codes stop the tick entirely.
    assign presc    = setup_r[SU_PRESC_LSB +: 3];
    assign rate_lim = 9'((PRESC_BASE << presc) - 1'b1);
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rate_cnt_r    <= 9'h000;
            rate_tick_out <= 1'b0;
        end else if (presc >= PRESC_RESERVED) begin
            rate_cnt_r    <= 9'h000;
            rate_tick_out <= 1'b0;
        end else if (rate_cnt_r >= rate_lim) begin
            rate_cnt_r    <= 9'h000;
            rate_tick_out <= 1'b1;
        end else begin
            rate_cnt_r    <= rate_cnt_r + 1'b1;
            rate_tick_out <= 1'b0;
        end
    end
endmodule : nc_dev

/* rtl/nc_host.sv */
`timescale 1ns/10ps
module nc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign in_ready_out  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid_out = cnt_r != '0;
    assign out_data_out  = store[rp_r];

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            store[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= push ? AW'(wp_r + 1'b1) : wp_r;
            rp_r  <= pop ? AW'(rp_r + 1'b1) : rp_r;
            cnt_r <= (AW+1)'(cnt_r + push - pop);
        end
    end
endmodule : nc_fifo

module nc_host
    import nc_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset.
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Register port toward the network core.
    nc_core_if.host          bus,
    // Transfer command.
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_read_in,
    input  wire logic [9:0]  cmd_addr_in,
    input  wire logic [10:0] cmd_len_in,
    input  wire logic        cmd_reg_in,
    output logic             cmd_ready_out,
    // Write data stream.
    input  wire logic        wdata_valid_in,
    input  wire logic [7:0]  wdata_in,
    output logic             wdata_ready_out,
    // Read data and completion.
    output logic             rdata_valid_out,
    output logic [7:0]       rdata_out,
    output logic             done_out,
    output logic [9:0]       done_ptr_out
);
    typedef enum {S_IDLE, S_HI, S_LO, S_GAP, S_XFER, S_WAIT,
                  S_PLO, S_PHI, S_PEND, S_FIN, S_REGD} nc_hstate_t;
    nc_hstate_t  st_r;
    logic        dir_r;
    logic [9:0]  addr_r;
    logic [10:0] left_r;
    logic [1:0]  gap_r;
    logic        was_rd_r;
    logic        f_valid;
    logic [7:0]  f_data;
    logic        f_pop;

    assign cmd_ready_out = st_r == S_IDLE;
    assign f_pop = st_r == S_XFER && !dir_r && left_r != '0 && f_valid;

    nc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .rst_in       (rst_in),
        .in_valid_in  (wdata_valid_in),
        .in_data_in   (wdata_in),
        .in_ready_out (wdata_ready_out),
        .out_valid_out(f_valid),
        .out_data_out (f_data),
        .out_ready_in (f_pop)
    );

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= S_IDLE;
            dir_r <= 1'b0;
            addr_r <= '0;
            left_r <= '0;
            gap_r <= '0;
            was_rd_r <= 1'b0;
            bus.addr <= 3'h0;
            bus.wdata <= 8'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            rdata_valid_out <= 1'b0;
            rdata_out <= 8'h00;
            done_out <= 1'b0;
            done_ptr_out <= '0;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            rdata_valid_out <= 1'b0;
            done_out <= 1'b0;
            case (st_r)
                S_IDLE: if (cmd_valid_in && cmd_reg_in) begin
                    // A register command carries its offset in the address
                    // field and its byte in the length field.
                    bus.addr  <= cmd_addr_in[2:0];
                    bus.wdata <= cmd_len_in[7:0];
                    bus.wr    <= 1'b1;
                    st_r      <= S_REGD;
                end else if (cmd_valid_in) begin
                    dir_r  <= cmd_read_in;
                    addr_r <= cmd_addr_in;
                    left_r <= cmd_len_in;
                    st_r   <= S_HI;
                end
                S_HI: begin
                    // High first, then low, always before a burst.
                    bus.addr  <= OFS_PTR_HI;
                    bus.wdata <= {dir_r, 1'b1, 4'h0, addr_r[9:8]};
                    bus.wr    <= 1'b1;
                    st_r      <= S_LO;
                end
                S_LO: begin
                    bus.addr  <= OFS_PTR_LO;
                    bus.wdata <= addr_r[7:0];
                    bus.wr    <= 1'b1;
                    gap_r     <= HOST_GAP;
                    was_rd_r  <= 1'b0;
                    st_r      <= S_GAP;
                end
                S_GAP: begin
                    gap_r <= gap_r - 1'b1;
                    if (gap_r == 2'h1) begin
                        st_r <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (left_r == '0) begin
                        st_r <= S_PLO;
                    end else if (dir_r) begin
                        bus.addr <= OFS_DATA;
                        bus.rd   <= 1'b1;
                        was_rd_r <= 1'b1;
                        left_r   <= left_r - 1'b1;
                        gap_r    <= HOST_GAP;
                        st_r     <= S_WAIT;
                    end else if (f_valid) begin
                        bus.addr  <= OFS_DATA;
                        bus.wdata <= f_data;
                        bus.wr    <= 1'b1;
                        was_rd_r  <= 1'b0;
                        left_r    <= left_r - 1'b1;
                        gap_r     <= HOST_GAP;
                        st_r      <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    // The gap covers a slowed commit or prefetch.
                    // The answer stands from the cycle after the strobe.
                    if (gap_r == HOST_GAP - 2'h1 && was_rd_r) begin
                        rdata_valid_out <= 1'b1;
                        rdata_out       <= bus.rdata;
                    end
                    gap_r <= gap_r - 1'b1;
                    if (gap_r == 2'h1) begin
                        st_r <= S_XFER;
                    end
                end
                S_PLO: begin
                    bus.addr <= OFS_PTR_LO;
                    bus.rd   <= 1'b1;
                    st_r     <= S_PHI;
                end
                S_PHI: begin
                    bus.addr <= OFS_PTR_HI;
                    bus.rd   <= 1'b1;
                    st_r     <= S_PEND;
                end
                S_PEND: begin
                    done_ptr_out[7:0] <= bus.rdata;
                    st_r     <= S_FIN;
                end
                S_FIN: begin
                    done_ptr_out[9:8] <= bus.rdata[1:0];
                    done_out <= 1'b1;
                    st_r     <= S_IDLE;
                end
                S_REGD: begin
                    done_out <= 1'b1;
                    st_r     <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule : nc_host

/* test/nc_bus_chk.sv */
`timescale 1ns/10ps
module nc_bus_chk
    import nc_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    logic [7:0] hi_r;
    logic       dacc;
    assign dacc = (wr || rd) && addr == OFS_DATA;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            hi_r <= 8'h00;
        end else if (wr && addr == OFS_PTR_HI) begin
            hi_r <= wdata;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    rdata_hold_a: assert property (
        !$past(rd) |-> $stable(rdata)) else $error("rdata moved");
    hi_then_lo_a: assert property (
        wr && addr == OFS_PTR_HI |=> wr && addr == OFS_PTR_LO)
        else $error("pointer low not next");
    lo_gap_a: assert property (
        wr && addr == OFS_PTR_LO |=> !dacc) else $error("early data");
    data_gap_a: assert property (
        dacc |=> !dacc [*2]) else $error("data gap short");
    hi_fmt_a: assert property (
        rd && addr == OFS_PTR_HI |=> rdata[5:2] == 4'h0)
        else $error("pointer high format");
    hi_mode_a: assert property (
        rd && addr == OFS_PTR_HI |=> rdata[7:6] == hi_r[7:6])
        else $error("pointer high mode");
    read_dir_a: assert property (
        rd && addr == OFS_DATA |-> hi_r[PH_READ_DIR])
        else $error("read in write mode");
    write_dir_a: assert property (
        wr && addr == OFS_DATA |-> !hi_r[PH_READ_DIR])
        else $error("write in read mode");
endmodule : nc_bus_chk

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top
    import nc_pkg::*;
();
    logic        clk_sys_in, rst_in, preq, rfs, rclr, rxv, cv, crd, wv, creg;
    logic [7:0]  rxd, wd, rdata_out;
    logic [9:0]  ca, done_ptr_out;
    logic [10:0] cl;
    logic [15:0] seed;
    logic        plo, poe, efl, acc, ack, dv3, rtk, atk;
    logic        crdy, wrdy, rdv, done_out;
    int          fails, check_count, mem [1024], exp_q [$];
    nc_core_if core_bus ();
    nc_dev nc_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .bus(core_bus.dev), .pulse_req_in(preq),
        .first_line_pulse_out(plo), .first_line_pulse_oe_n_out(poe),
        .refusal_in(rfs), .refusal_clr_in(rclr),
        .excess_refusal_flag_out(efl), .rx_valid_in(rxv),
        .rx_dest_id_in(rxd), .rx_accept_out(acc), .rx_ack_out(ack),
        .timeout_divide_three_out(dv3), .rate_tick_out(rtk),
        .arb_tick_out(atk));
    nc_host nc_host_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .bus(core_bus.host), .cmd_valid_in(cv), .cmd_read_in(crd),
        .cmd_addr_in(ca), .cmd_len_in(cl), .cmd_ready_out(crdy),
        .cmd_reg_in(creg),
        .wdata_valid_in(wv), .wdata_in(wd), .wdata_ready_out(wrdy),
        .rdata_valid_out(rdv), .rdata_out(rdata_out),
        .done_out(done_out), .done_ptr_out(done_ptr_out));
    nc_bus_chk nc_bus_chk_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .addr(core_bus.addr), .wdata(core_bus.wdata), .wr(core_bus.wr),
        .rd(core_bus.rd), .rdata(core_bus.rdata));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask : tick
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [15:0] e, g);
        check_count++;
        if (e !== g) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Mode 1 expects open drain and promiscuous receive, mode 0 neither.
    task automatic line_rx(input logic m);
        logic own;
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            {preq, rxv} = seed[1:0];
            rxd = seed[2] ? 8'h00 : seed[15:8];
            own = rxv && rxd == 8'h00;
            tick();
            chk("pulse", 16'(!preq && !m), 16'(plo));
            chk("pulse_oe_n", 16'(!preq && m), 16'(poe));
            chk("accept", 16'(own || (rxv && m)), 16'(acc));
            chk("ack", 16'(own), 16'(ack));
        end
    endtask : line_rx
    task automatic timing(input logic [15:0] er, ea);
        logic [15:0] r, a;
        r = 16'h0000;
        a = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            r += 16'(rtk);
            a += 16'(atk);
            tick();
        end
        chk("rate_ticks", er, r);
        chk("arb_ticks", ea, a);
    endtask : timing
    // A register command writes one byte to one offset on the core port.
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        int c;
        {cv, creg, ca, cl} = {2'h3, 10'(a), 11'(d)};
        tick();
        {cv, creg} = 2'h0;
        for (c = 0; c < 9 && done_out !== 1'b1; c++) tick();
        if (c >= 9) begin
            fails++;
            stop_test();
        end
    endtask : reg_wr
    // Bytes come back in issue order, so the queue front is the next one.
    task automatic run(input logic r, input int a, input int n);
        int c;
        c = 0;
        cv = 1'b1;
        crd = r;
        ca = 10'(a);
        cl = 11'(n);
        while (crdy !== 1'b1 && c < 99) begin
            tick();
            c++;
        end
        if (c >= 99) begin
            fails++;
            stop_test();
        end
        tick();
        cv = 1'b0;
        for (c = 0; c < 999 && done_out !== 1'b1; c++) begin
            if (rdv === 1'b1) chk("rdata", 16'(exp_q.pop_front()), 16'(rdata_out));
            tick();
        end
        if (c >= 999) begin
            fails++;
            stop_test();
        end
        chk("done_ptr", 16'((a + n) % 1024), 16'(done_ptr_out));
        chk("left", 16'h0000, 16'(exp_q.size()));
    endtask : run
    initial begin
        {preq, rfs, rclr, rxv, cv, crd, wv, creg, rxd, wd, ca, cl} = '0;
        {rst_in, seed} = {1'b1, 16'hb2a9};
        repeat (6) tick();
        rst_in = 1'b0;
        wv = 1'b1;
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            wd = seed[7:0];
            mem[(1010 + i) % 1024] = seed[7:0];
            chk("wready", 16'h0001, 16'(wrdy));
            tick();
        end
        chk("full", 16'h0000, 16'(wrdy));
        wv = 1'b0;
        run(1'b0, 1010, 32);
        for (int i = 0; i < 32; i++) exp_q.push_back(mem[(1010 + i) % 1024]);
        run(1'b1, 1010, 32);
        for (int i = 0; i < 5; i++) exp_q.push_back(mem[(1020 + i) % 1024]);
        run(1'b1, 1020, 5);
        $display("test ram port done");
        line_rx(1'b0);
        $display("test line and receive done");
        for (int i = 1; i <= 128; i++) begin
            rfs = 1'b1;
            tick();
            rfs = 1'b0;
            tick();
            if (i >= 127) chk("refuse_flag", 16'(i == 128), 16'(efl));
        end
        rclr = 1'b1;
        tick();
        rclr = 1'b0;
        tick();
        chk("refuse_clr", 16'h0000, 16'(efl));
        $display("test refusal done");
        timing(16'h0008, 16'h0040);
        chk("div3", 16'h0000, 16'(dv3));
        $display("test timing done");
        // Backplane with subaddress 10, then open drain, four refusals,
        // timeouts by three, promiscuous, divisor 16 and slow arbitration.
        reg_wr(OFS_CONFIG, {5'h00, 1'b1, SUB_SETUP});
        reg_wr(OFS_SUBREG, 8'h73);
        line_rx(1'b1);
        // The fourth refusal meets a clear in the same cycle; the set wins.
        for (int i = 1; i <= 4; i++) begin
            rfs = 1'b1;
            rclr = 1'(i == 4);
            tick();
            {rfs, rclr} = 2'h0;
            tick();
            chk("refuse_four", 16'(i == 4), 16'(efl));
        end
        timing(16'h0004, 16'h0020);
        chk("div3", 16'h0001, 16'(dv3));
        $display("test setup done");
        stop_test();
    end
endmodule : tb_top
